// [pkg/prog_map_pkg.sv]
// Summary of operation
// [R1] 21-bit counter spans 2-Mbyte program space
// [R2] fetch above on-chip memory returns zeros
// [R3] reset vector 0000h, interrupts 0008h, 0018h
// [R4] on-chip flash 48 or 64 Kbytes
// [R5] program and data ports work concurrently
// [R6] wake-up interrupt leaves a flag set; here it clears in the first run cycle without sleep or wake input
// [R7] enabled wake-up interrupt loads matching vector
// [R8] wake-up interrupt pushes counter onto stack
// [R9] port A bit 6 only in io oscillator modes
// [R10] unimplemented port A bit 6 reads zero
// [R11] reset pin disabled makes port G bit5 input
// [R12] internal-only mode: memory control reads zero
// [R13] resets load defaults, wake-up keeps contents
// [R14] top of flash BFFFh or FFFFh
package prog_map_pkg;

  // ****************************************************************
  // address map and vectors
  // ****************************************************************
  localparam int          PC_W          = 21;
  localparam logic [20:0] RESET_VECTOR  = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR   = 21'h000008;
  localparam logic [20:0] LOW_VECTOR    = 21'h000018;
  localparam logic [20:0] TOP_SMALL     = 21'h00bfff;
  localparam logic [20:0] TOP_LARGE     = 21'h00ffff;
  localparam logic [15:0] NOP_WORD      = 16'h0000;
  localparam int          STACK_DEPTH   = 31;
  localparam logic [4:0]  SP_RESET      = 5'h00;
  localparam logic [7:0]  MEMCTL_RESET  = 8'h00;
  localparam int          PA_OPT_BIT    = 6;
  localparam int          PG_RST_BIT    = 5;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10
  } run_state_t;

  typedef struct packed {
    logic        valid;
    logic [20:0] addr;
  } fetch_req_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] high;
    logic [7:0] low;
  } tos_t;

endpackage

// [logic/prog_map.sv]
`timescale 1ns/1ps
`default_nettype none
module prog_map #(
  parameter bit LARGE_VARIANT = 1'b1,   // 64 Kbyte flash when set
  parameter bit PA6_EXISTS    = 1'b1
) (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    resetn_i,
  // core fetch side
  input  wire prog_map_pkg::fetch_req_t fetch_i,
  output var  logic [15:0]             fetch_data_o,
  output var  logic                    fetch_valid_o,
  // flash side
  output var  logic [15:0]             flash_addr_o,
  output var  logic                    flash_rd_o,
  input  wire logic [15:0]             flash_data_i,
  // data bus side, independent of fetch
  input  wire logic                    data_rd_i,
  output var  logic                    data_busy_o,
  // control from core
  input  wire logic                    sleep_i,
  input  wire logic                    wake_high_i,
  input  wire logic                    wake_low_i,
  input  wire logic                    high_priority_global_int_enable_i,
  input  wire logic                    low_priority_global_int_enable_i,
  input  wire logic [20:0]             pc_next_i,
  // configuration
  input  wire logic                    external_clock_io_osc_mode_i,
  input  wire logic                    rc_io_osc_mode_i,
  input  wire logic                    external_reset_pin_en_i,
  input  wire logic                    internal_only_mode_i,
  // port gating
  input  wire logic [7:0]              port_a_pins_i,
  input  wire logic [7:0]              port_a_latch_i,
  input  wire logic [7:0]              port_a_direction_i,
  input  wire logic [7:0]              port_g_pins_i,
  input  wire logic [7:0]              memory_interface_control_i,
  output var  logic [7:0]              port_a_pins_o,
  output var  logic [7:0]              port_a_latch_o,
  output var  logic [7:0]              port_a_direction_o,
  output var  logic                    port_g5_writable_o,
  output var  logic [7:0]              memory_interface_control_o,
  // program counter and stack
  output var  logic [20:0]             pc_o,
  output var  logic [4:0]              return_stack_pointer_o,
  output var  prog_map_pkg::tos_t      top_of_stack_o,
  output var  logic                    wake_flag_o
);
  import prog_map_pkg::*;

  // ****************************************************************
  // fetch decode
  // ****************************************************************
  // top of flash depends only on the variant
  function automatic logic in_flash(input logic [20:0] a);
    in_flash = (a <= (LARGE_VARIANT ? TOP_LARGE : TOP_SMALL)); // [R4] [R14]
  endfunction

  logic [15:0] fdata_d, fdata_q;
  logic        fvalid_d, fvalid_q, fhit_q, fhit_d;
  logic [15:0] faddr_d, faddr_q;
  logic        frd_d, frd_q;
  logic        dbusy_d, dbusy_q;

  // one-cycle flash issue, data returned the next cycle
  always_comb begin
    faddr_d  = fetch_i.addr[15:0];                   // [R1]
    frd_d    = fetch_i.valid && in_flash(fetch_i.addr);
    fhit_d   = frd_d;
    fvalid_d = fetch_i.valid;
    // out-of-range fetches read zero, a no-operation
    fdata_d  = fhit_q ? flash_data_i : NOP_WORD;     // [R2] [R14]
    dbusy_d  = 1'b0; // data bus never waits on fetch  [R5]
    if (data_rd_i) begin
      dbusy_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      faddr_q  <= 16'h0000;
      frd_q    <= 1'b0;
      fhit_q   <= 1'b0;
      fvalid_q <= 1'b0;
      fdata_q  <= 16'h0000;
      dbusy_q  <= 1'b0;
    end else begin
      faddr_q  <= faddr_d;
      frd_q    <= frd_d;
      fhit_q   <= fhit_d;
      fvalid_q <= fvalid_d;
      fdata_q  <= fdata_d;
      dbusy_q  <= dbusy_d;
    end
  end

  assign flash_addr_o  = faddr_q;
  assign flash_rd_o    = frd_q;
  assign data_busy_o   = dbusy_q;

  // data output registered one stage after flash returns
  logic        fv2_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fv2_q <= 1'b0;
    end else begin
      fv2_q <= fvalid_q;
    end
  end
  assign fetch_data_o  = fdata_q;
  assign fetch_valid_o = fv2_q;

  // ****************************************************************
  // sleep, wake-up vectoring and stack push
  // ****************************************************************
  run_state_t  st_d, st_q;
  logic [20:0] pc_d, pc_q;
  logic [4:0]  sp_d, sp_q;
  tos_t        tos_d, tos_q;
  logic        wflag_d, wflag_q;
  logic        wake_any;
  // source remembered across the wake cycle
  logic        wake_high_i_q, wake_low_i_q;

  assign wake_any = wake_high_i || wake_low_i;

  always_comb begin
    st_d    = st_q;
    pc_d    = pc_next_i;
    sp_d    = sp_q;
    tos_d   = tos_q;
    wflag_d = wflag_q;
    case (st_q)
      ST_RUN: begin
        if (sleep_i) begin
          st_d = ST_SLEEP;
          pc_d = pc_q;
        end
      end
      ST_SLEEP: begin
        pc_d = pc_q; // counter holds while asleep
        if (wake_any) begin
          st_d    = ST_WAKE;
          wflag_d = 1'b1;                            // [R6]
        end
      end
      ST_WAKE: begin
        st_d = ST_RUN;
        pc_d = pc_q;
        if (wake_high_i_q && high_priority_global_int_enable_i) begin
          pc_d = HIGH_VECTOR;                        // [R7] [R3]
        end else if (wake_low_i_q && low_priority_global_int_enable_i) begin
          pc_d = LOW_VECTOR;                         // [R7] [R3]
        end
        if ((wake_high_i_q && high_priority_global_int_enable_i) ||
            (wake_low_i_q && low_priority_global_int_enable_i)) begin
          // push: pointer moves and the slot takes the counter on the same edge
          if (sp_q != 5'(STACK_DEPTH)) begin
            sp_d = sp_q + 5'd1;                      // [R8]
          end
          tos_d = {3'b000, pc_q};                    // [R8]
        end
      end
      default: st_d = ST_RUN;
    endcase
    // a new wake event wins over a run-state clear
    if (st_q == ST_RUN && !sleep_i && !wake_any) begin
      wflag_d = 1'b0;
    end
  end

  // every reset reloads defaults; wake-up only updates what it touches
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q          <= ST_RUN;
      pc_q          <= RESET_VECTOR;                 // [R3] [R13]
      sp_q          <= SP_RESET;                     // [R13]
      tos_q         <= '0;
      wflag_q       <= 1'b0;
      wake_high_i_q <= 1'b0;
      wake_low_i_q  <= 1'b0;
    end else begin
      st_q          <= st_d;
      pc_q          <= pc_d;
      sp_q          <= sp_d;
      tos_q         <= tos_d;
      wflag_q       <= wflag_d;
      wake_high_i_q <= wake_high_i;
      wake_low_i_q  <= wake_low_i;
    end
  end

  assign pc_o                   = pc_q;
  assign return_stack_pointer_o = sp_q;
  assign top_of_stack_o         = tos_q;
  assign wake_flag_o            = wflag_q;

  // ****************************************************************
  // port and register gating
  // ****************************************************************
  logic [7:0] pa_d, pa_q, la_d, la_q, ta_d, ta_q, mc_d, mc_q;
  logic       g5w_d, g5w_q, a6_en;

  // bit 6 lives only when present and clocking frees the pin
  assign a6_en = PA6_EXISTS &&
                 (external_clock_io_osc_mode_i || rc_io_osc_mode_i); // [R9] [R10]

  always_comb begin
    pa_d = port_a_pins_i;
    la_d = port_a_latch_i;
    ta_d = port_a_direction_i;
    pa_d[PA_OPT_BIT] = a6_en & port_a_pins_i[PA_OPT_BIT];       // [R9]
    la_d[PA_OPT_BIT] = a6_en & port_a_latch_i[PA_OPT_BIT];      // [R10]
    ta_d[PA_OPT_BIT] = a6_en & port_a_direction_i[PA_OPT_BIT];  // [R9]
    g5w_d = external_reset_pin_en_i;                 // [R11]
    mc_d  = internal_only_mode_i ? MEMCTL_RESET
                                 : memory_interface_control_i; // [R12]
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_q  <= 8'h00;
      la_q  <= 8'h00;
      ta_q  <= 8'h00;
      g5w_q <= 1'b0;
      mc_q  <= MEMCTL_RESET;
    end else begin
      pa_q  <= pa_d;
      la_q  <= la_d;
      ta_q  <= ta_d;
      g5w_q <= g5w_d;
      mc_q  <= mc_d;
    end
  end

  assign port_a_pins_o              = pa_q;
  assign port_a_latch_o             = la_q;
  assign port_a_direction_o         = ta_q;
  assign port_g5_writable_o         = g5w_q;
  assign memory_interface_control_o = mc_q;

endmodule // prog_map
`default_nettype wire

// [bench/flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// flash stand-in: word per address, inverted when the bus is released
// ****
module flash_model (
  // flash side of the block
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  output var  logic [15:0] data_o
);
  // inverse off-read so a stale word is never mistaken for a fetch
  always_comb data_o = rd_i ? addr_i ^ 16'ha5a5 : ~(addr_i ^ 16'ha5a5);
endmodule // flash_model
`default_nettype wire

// [bench/prog_map_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// port-level checks on the map block
// ****
module prog_map_sva #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit PA6_EXISTS    = 1'b1
) (
  input wire logic                     clock_i,
  input wire logic                     resetn_i,
  input wire prog_map_pkg::fetch_req_t fetch_i,
  input wire logic [15:0]              fetch_data_o,
  input wire logic                     fetch_valid_o,
  input wire logic                     flash_rd_o,
  input wire logic [15:0]              flash_data_i,
  input wire logic                     wake_high_i,
  input wire logic                     wake_low_i,
  input wire logic                     high_priority_global_int_enable_i,
  input wire logic                     low_priority_global_int_enable_i,
  input wire logic                     external_clock_io_osc_mode_i,
  input wire logic                     rc_io_osc_mode_i,
  input wire logic [7:0]               port_a_pins_i,
  input wire logic [7:0]               port_a_pins_o,
  input wire logic [20:0]              pc_o,
  input wire logic [4:0]               return_stack_pointer_o,
  input wire prog_map_pkg::tos_t       top_of_stack_o,
  input wire logic                     wake_flag_o
);
  import prog_map_pkg::*;
  logic [20:0] top;
  logic        a6_on;
  // bit 6 lives only on parts that have it and in the two io modes
  assign top = LARGE_VARIANT ? TOP_LARGE : TOP_SMALL;
  assign a6_on = PA6_EXISTS
    && (external_clock_io_osc_mode_i || rc_io_osc_mode_i);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  reset_start_a: assert property (!$past(resetn_i) |->
    pc_o == RESET_VECTOR && return_stack_pointer_o == SP_RESET)
    else $error("pc or stack not cleared by reset");
  fetch_lat_a: assert property (fetch_i.valid |-> ##2 fetch_valid_o)
    else $error("fetch answer late or missing");
  above_nop_a: assert property (fetch_i.valid &&
    fetch_i.addr > top |-> ##2 fetch_data_o == NOP_WORD)
    else $error("fetch above top not zero");
  flash_rd_a: assert property (fetch_i.valid |=>
    flash_rd_o == ($past(fetch_i.addr) <= top))
    else $error("flash read does not match address range");
  flash_data_a: assert property (flash_rd_o |=>
    fetch_data_o == $past(flash_data_i)) else $error("flash word lost");
  // the flag rises on entry to the wake cycle, the vector lands after it
  wake_vec_a: assert property ($rose(wake_flag_o) &&
    (($past(wake_high_i) && high_priority_global_int_enable_i) ||
     ($past(wake_low_i) && low_priority_global_int_enable_i)) |=>
    pc_o == (($past(wake_high_i, 2) &&
      $past(high_priority_global_int_enable_i)) ? HIGH_VECTOR : LOW_VECTOR))
    else $error("wake without interrupt vector");
  wake_push_a: assert property ($rose(wake_flag_o) &&
    (($past(wake_high_i) && high_priority_global_int_enable_i) ||
     ($past(wake_low_i) && low_priority_global_int_enable_i)) |=>
    top_of_stack_o == {3'h0, $past(pc_o)} && return_stack_pointer_o ==
    $past(return_stack_pointer_o) + ($past(return_stack_pointer_o) != 5'h1f))
    else $error("wake did not push the counter");
  port_a_pins_gate_a: assert property ($past(resetn_i) |->
    port_a_pins_o == ($past(port_a_pins_i) & {1'b1, $past(a6_on), 6'h3f}))
    else $error("port a bit 6 not gated");
endmodule // prog_map_sva
bind prog_map prog_map_sva #(.LARGE_VARIANT(LARGE_VARIANT),
  .PA6_EXISTS(PA6_EXISTS)) i_prog_map_sva (.*);
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// bench for the program map block
// ****
module tb;
  import prog_map_pkg::*;
  logic clock_i, resetn_i, flash_rd_o, fetch_valid_o, data_rd_i, data_busy_o;
  logic sleep_i, wake_high_i, wake_low_i, wake_flag_o, port_g5_writable_o;
  logic high_priority_global_int_enable_i, low_priority_global_int_enable_i;
  logic external_clock_io_osc_mode_i, rc_io_osc_mode_i, internal_only_mode_i;
  logic external_reset_pin_en_i;
  logic [15:0] fetch_data_o, flash_addr_o, flash_data_i;
  logic [20:0] pc_next_i, pc_o;
  logic [7:0] port_a_pins_i, port_a_latch_i, port_a_direction_i, port_g_pins_i;
  logic [7:0] port_a_pins_o, port_a_latch_o, port_a_direction_o;
  logic [7:0] memory_interface_control_i, memory_interface_control_o;
  logic [4:0] return_stack_pointer_o;
  fetch_req_t fetch_i;
  tos_t top_of_stack_o;
  int bad_count = 0;
  int n_tests = 0;
  // address beside expected word: flash pattern in range, zero above it
  logic [36:0] rows [5] = '{{21'h000000, 16'ha5a5}, {21'h00ffff, 16'h5a5a},
    {21'h000018, 16'ha5bd}, {21'h010000, 16'h0000}, {21'h1fffff, 16'h0000}};
  prog_map i_prog_map (.*);
  flash_model i_flash_model (.addr_i(flash_addr_o), .rd_i(flash_rd_o),
    .data_o(flash_data_i));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // sleep, wake from one source, then look at flag, vector and stack
  task automatic wake(input logic [1:0] src, input logic [20:0] pcv,
                      input logic [20:0] vec, input logic [4:0] sp);
    step(1);
    pc_next_i <= pcv;
    {high_priority_global_int_enable_i,
     low_priority_global_int_enable_i} <= src;
    step(3);
    sleep_i <= 1'b1;
    step(1);
    sleep_i <= 1'b0;
    {wake_high_i, wake_low_i} <= src;
    step(1);
    {wake_high_i, wake_low_i} <= 2'b00;
    #1;
    chk(24'(wake_flag_o), 24'h000001);
    // vector and push land one cycle after the flag; the flag still stands then
    step(1);
    #1;
    chk(24'(pc_o), 24'(vec));
    chk(top_of_stack_o, 24'(pcv));
    chk(24'(return_stack_pointer_o), 24'(sp));
    chk(24'(wake_flag_o), 24'h000001);
  endtask
  initial begin
    resetn_i = 1'b0;
    fetch_i = '0;
    pc_next_i = '0;
    {sleep_i, wake_high_i, wake_low_i, data_rd_i, internal_only_mode_i} = '0;
    {high_priority_global_int_enable_i, low_priority_global_int_enable_i} = '0;
    {external_clock_io_osc_mode_i, rc_io_osc_mode_i} = 2'b10;
    external_reset_pin_en_i = 1'b1;
    {port_a_pins_i, port_a_latch_i, port_a_direction_i} = 24'hffffff;
    port_g_pins_i = 8'h20;
    memory_interface_control_i = 8'h5c;
    step(5);
    resetn_i <= 1'b1;
    data_rd_i <= 1'b1;
    #1;
    chk(24'(pc_o), 24'(RESET_VECTOR));
    chk(24'(fetch_valid_o), 24'h000000);
    step(1);
    #1;
    chk(24'(pc_o), 24'(RESET_VECTOR));
    chk(24'(data_busy_o), 24'h000000);
    foreach (rows[k]) begin
      step(1);
      fetch_i <= '{1'b1, rows[k][36:16]};
      step(1);
      fetch_i.valid <= 1'b0;
      #1;
      chk(24'(flash_addr_o), 24'(rows[k][31:16]));
      chk(24'(flash_rd_o), 24'(rows[k][36:16] <= TOP_LARGE));
      // the answer stands for the one cycle after the flash read
      step(1);
      #1;
      chk(24'(fetch_valid_o), 24'h000001);
      chk(24'(fetch_data_o), 24'(rows[k][15:0]));
    end
    // every oscillator pairing, memory mode and reset pin setting
    for (int m = 0; m < 4; m++) begin
      step(1);
      {external_clock_io_osc_mode_i, rc_io_osc_mode_i} <= m[1:0];
      internal_only_mode_i <= m[0];
      external_reset_pin_en_i <= m[1];
      step(1);
      #1;
      chk(24'(port_a_pins_o), (m != 0) ? 24'hff : 24'hbf);
      chk(24'(port_a_latch_o), (m != 0) ? 24'hff : 24'hbf);
      chk(24'(port_a_direction_o), (m != 0) ? 24'hff : 24'hbf);
      chk(24'(memory_interface_control_o), m[0] ? 24'h00 : 24'h5c);
      chk(24'(port_g5_writable_o), 24'(m[1]));
    end
    wake(2'b10, 21'h000123, HIGH_VECTOR, 5'h01);
    wake(2'b01, 21'h00abcd, LOW_VECTOR, 5'h02);
    // reset in mid-run must drop the pushed state again
    step(1);
    resetn_i <= 1'b0;
    step(2);
    #1;
    chk(24'(pc_o), 24'(RESET_VECTOR));
    chk(24'(return_stack_pointer_o), 24'(SP_RESET));
    chk(top_of_stack_o, 24'h000000);
    chk(24'(wake_flag_o), 24'h000000);
    step(1);
    resetn_i <= 1'b1;
    #1;
    chk(24'(pc_o), 24'(RESET_VECTOR));
    step(2);
    results();
  end
  // the whole run needs about fifty cycles; 2000 means a hang
  initial begin
    #(4 * 2000);
    bad_count++;
    results();
  end
endmodule // tb
`default_nettype wire
